/* File: inc/core_mode_defs.svh */
// constants for the core mode register and stack pointer block
//
// Contract
// - mode register reads E0h after reset.
// - bit 7 set puts system stack in register file, clear in memory.
// - bit 6 set puts user stack in register file, clear in memory.
// - bit 5 set halves oscillator clock, clear passes it undivided.
// - bits 4 to 2 set core clock division from 1 to 8.
// - bit 1 lets the bus request pin through; clear ignores it.
// - bit 0 set floats address/data and strobe lines; clearing it drives them again.
// - pins configured as general I/O never float from bit 0.
// - push pre-decrements pointer, pop post-increments; stacks grow downward.
// - a pop never alters the location it reads.
// - interrupt pushes PC and flags, plus code segment if enabled.
// - near call pushes PC; segment call pushes PC and code segment.
// - link reserves a programmable frame on system or user stack.
// - returns and unlink pop the same items their counterparts pushed.
// - system stack by default, user variant selectable, word variant 16 bits.
// - register-file stack uses only pointer low byte; high byte reserved.
// - user pointer at 236/237, system pointer at 238/239.
`ifndef CORE_MODE_DEFS_SVH
`define CORE_MODE_DEFS_SVH
`define MODE_ADDR       8'heb
`define UPTR_HIGH_ADDR  8'hec
`define UPTR_LOW_ADDR   8'hed
`define SPTR_HIGH_ADDR  8'hee
`define SPTR_LOW_ADDR   8'hef
`define MODE_RESET      8'he0
`define MODE_SYSLOC_BIT 7
`define MODE_USRLOC_BIT 6
`define MODE_HALF_BIT   5
`define MODE_SCALE_HI   4
`define MODE_SCALE_LO   2
`define MODE_BRQ_BIT    1
`define MODE_FLOAT_BIT  0
`endif

/* File: inc/core_mode_pkg.sv */
// types for the core mode and stack pointer block
package core_mode_pkg;
    // stack engine sequencer, gray coded
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_WRITE = 3'b001,
        ST_READ  = 3'b011,
        ST_DONE  = 3'b010
    } stack_state_e;

    // stack operations requested by the core
    typedef enum logic [3:0] {
        OP_NONE    = 4'h0,
        OP_PUSH    = 4'h1,
        OP_POP     = 4'h2,
        OP_INT     = 4'h3,
        OP_CALL    = 4'h4,
        OP_CALLS   = 4'h5,
        OP_LINK    = 4'h6,
        OP_IRET    = 4'h7,
        OP_RET     = 4'h8,
        OP_RETS    = 4'h9,
        OP_UNLINK  = 4'ha
    } stack_op_e;
endpackage : core_mode_pkg

/* File: src/clock_prescaler.sv */
// oscillator halving and core clock prescale enable generator
`timescale 1ns/1ns
module clock_prescaler
    import core_mode_pkg::*;
(
    // clock and reset
    input  wire logic       clock,
    input  wire logic       resetn,
    // settings
    input  wire logic       oscHalving,
    input  wire logic [2:0] coreClockPrescale,
    // tick out
    output logic            coreTick
);
    logic       halfPhase_reg;
    logic [2:0] count_reg;
    logic       oscTick;

    // divide-by-2 stage on the oscillator
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            halfPhase_reg <= 1'b0;
        end else begin
            halfPhase_reg <= ~halfPhase_reg;
        end
    end
    assign oscTick = oscHalving ? halfPhase_reg : 1'b1;

    // prescaler counts field value plus one oscillator ticks
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            count_reg <= 3'h0;
            coreTick  <= 1'b0;
        end else begin
            coreTick <= 1'b0;
            if (oscTick) begin
                if (count_reg >= coreClockPrescale) begin
                    count_reg <= 3'h0;
                    coreTick  <= 1'b1;
                end else begin
                    count_reg <= count_reg + 3'h1;
                end
            end
        end
    end
endmodule : clock_prescaler

/* File: src/core_mode_stack.sv */
// mode control register, stack pointers and stack sequencer
`timescale 1ns/1ns
`include "core_mode_defs.svh"
module core_mode_stack
    import core_mode_pkg::*;
#(
    parameter int PORT_W = 8
) (
    // clock and reset
    input  wire logic              clock,
    input  wire logic              resetn,
    // register file port
    input  wire logic [7:0]        regAddr,
    input  wire logic              regWrite,
    input  wire logic [7:0]        regWdata,
    output logic [7:0]             regRdata,
    // stack operation request
    input  wire logic              opStart,
    input  wire logic [3:0]        opCode,
    input  wire logic              opUser,
    input  wire logic              opWord,
    input  wire logic [15:0]       opData,
    input  wire logic [15:0]       opPc,
    input  wire logic [7:0]        opFlags,
    input  wire logic [7:0]        opCodeSeg,
    input  wire logic [15:0]       opFrameLen,
    input  wire logic              segmentSaveEnable,
    output logic                   opBusy,
    output logic                   opDone,
    output logic [15:0]            popData,
    output logic [15:0]            popPc,
    output logic [7:0]             popFlags,
    output logic [7:0]             popCodeSeg,
    // stack storage access
    output logic                   stkReq,
    output logic                   stkWrite,
    output logic                   stkInRegFile,
    output logic [15:0]            stkAddr,
    output logic [7:0]             stkWdata,
    input  wire logic [7:0]        stkRdata,
    // clock and external bus
    input  wire logic              busRequestPin,
    input  wire logic [PORT_W-1:0] portIsAddress,
    output logic                   coreTick,
    output logic                   busRequest,
    output logic [PORT_W-1:0]      portFloat,
    output logic                   ctrlFloat
);
    logic [7:0]   mode_reg;
    logic [15:0]  userPtr_reg;
    logic [15:0]  sysPtr_reg;
    stack_state_e state_reg;
    logic [3:0]   op_reg;
    logic         user_reg;
    logic [2:0]   left_reg;
    logic [7:0]   item_reg [0:7];
    logic [2:0]   idx_reg;
    logic [15:0]  frame_reg;
    logic [2:0]   pushCount;
    logic [2:0]   popCount;
    logic         isPush;
    logic [15:0]  curPtr;
    logic         curInt;

    // mode register and pointer writes, stack pointer updates
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            mode_reg    <= `MODE_RESET;
            userPtr_reg <= 16'h0000;
            sysPtr_reg  <= 16'h0000;
        end else begin
            if (regWrite) begin
                case (regAddr)
                    `MODE_ADDR:      mode_reg          <= regWdata;
                    `UPTR_HIGH_ADDR: userPtr_reg[15:8] <= regWdata;
                    `UPTR_LOW_ADDR:  userPtr_reg[7:0]  <= regWdata;
                    `SPTR_HIGH_ADDR: sysPtr_reg[15:8]  <= regWdata;
                    `SPTR_LOW_ADDR:  sysPtr_reg[7:0]   <= regWdata;
                    default: ;
                endcase
            end
            if (state_reg == ST_WRITE) begin
                // pre-decrement before each pushed byte
                if (user_reg) userPtr_reg <= userPtr_reg - 16'h0001;
                else          sysPtr_reg  <= sysPtr_reg - 16'h0001;
            end else if (state_reg == ST_READ) begin
                // post-increment after each popped byte
                if (user_reg) userPtr_reg <= userPtr_reg + 16'h0001;
                else          sysPtr_reg  <= sysPtr_reg + 16'h0001;
            end else if (state_reg == ST_DONE && op_reg == OP_LINK) begin
                // reserve the frame below the saved frame pointer
                if (user_reg) userPtr_reg <= userPtr_reg - frame_reg;
                else          sysPtr_reg  <= sysPtr_reg - frame_reg;
            end
        end
    end

    // register read mux
    always_comb begin
        case (regAddr)
            `MODE_ADDR:     regRdata = mode_reg;
            `UPTR_HIGH_ADDR: regRdata = userPtr_reg[15:8];
            `UPTR_LOW_ADDR:  regRdata = userPtr_reg[7:0];
            `SPTR_HIGH_ADDR: regRdata = sysPtr_reg[15:8];
            `SPTR_LOW_ADDR:  regRdata = sysPtr_reg[7:0];
            default:        regRdata = 8'h00;
        endcase
    end

    // byte counts for each operation; return pops what entry pushed
    always_comb begin
        pushCount = 3'h0;
        popCount  = 3'h0;
        case (opCode)
            OP_PUSH:   pushCount = opWord ? 3'h2 : 3'h1;
            OP_POP:    popCount  = opWord ? 3'h2 : 3'h1;
            OP_INT:    pushCount = segmentSaveEnable ? 3'h4 : 3'h3;
            OP_CALL:   pushCount = 3'h2;
            OP_CALLS:  pushCount = 3'h3;
            OP_LINK:   pushCount = 3'h2;
            OP_IRET:   popCount  = segmentSaveEnable ? 3'h4 : 3'h3;
            OP_RET:    popCount  = 3'h2;
            OP_RETS:   popCount  = 3'h3;
            OP_UNLINK: popCount  = 3'h2;
            default: ;
        endcase
    end

    assign isPush = (pushCount != 3'h0);
    assign curPtr = user_reg ? userPtr_reg : sysPtr_reg;
    // stack location: 1 means register file
    assign curInt = user_reg ? mode_reg[`MODE_USRLOC_BIT]
                             : mode_reg[`MODE_SYSLOC_BIT];

    // sequencer; items are laid out high byte first in item_reg
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_reg <= ST_IDLE;
            op_reg    <= OP_NONE;
            user_reg  <= 1'b0;
            left_reg  <= 3'h0;
            idx_reg   <= 3'h0;
            frame_reg <= 16'h0000;
            opDone    <= 1'b0;
            for (int i = 0; i < 8; i++) item_reg[i] <= 8'h00;
        end else begin
            opDone <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (opStart && opCode != OP_NONE) begin
                        op_reg    <= opCode;
                        // only explicit variants may use the user stack
                        user_reg  <= opUser && (opCode == OP_PUSH ||
                                     opCode == OP_POP || opCode == OP_LINK ||
                                     opCode == OP_UNLINK);
                        frame_reg <= opFrameLen;
                        // memory order low address first: last pushed
                        case (opCode)
                            OP_INT: begin
                                item_reg[0] <= opFlags;
                                item_reg[1] <= opPc[15:8];
                                item_reg[2] <= opPc[7:0];
                                item_reg[3] <= opCodeSeg;
                            end
                            OP_CALLS: begin
                                item_reg[0] <= opPc[15:8];
                                item_reg[1] <= opPc[7:0];
                                item_reg[2] <= opCodeSeg;
                            end
                            OP_CALL, OP_LINK: begin
                                item_reg[0] <= opPc[15:8];
                                item_reg[1] <= opPc[7:0];
                            end
                            default: begin
                                item_reg[0] <= opWord ? opData[15:8]
                                                      : opData[7:0];
                                item_reg[1] <= opData[7:0];
                            end
                        endcase
                        if (opCode == OP_LINK) begin
                            item_reg[0] <= opData[15:8];
                            item_reg[1] <= opData[7:0];
                        end
                        if (isPush) begin
                            left_reg  <= pushCount;
                            idx_reg   <= pushCount - 3'h1;
                            state_reg <= ST_WRITE;
                        end else begin
                            left_reg  <= popCount;
                            idx_reg   <= 3'h0;
                            state_reg <= ST_READ;
                        end
                    end
                end
                ST_WRITE: begin
                    // highest item first so first item ends lowest
                    idx_reg  <= idx_reg - 3'h1;
                    left_reg <= left_reg - 3'h1;
                    if (left_reg == 3'h1) state_reg <= ST_DONE;
                end
                ST_READ: begin
                    item_reg[idx_reg] <= stkRdata;
                    idx_reg  <= idx_reg + 3'h1;
                    left_reg <= left_reg - 3'h1;
                    if (left_reg == 3'h1) state_reg <= ST_DONE;
                end
                ST_DONE: begin
                    opDone    <= 1'b1;
                    state_reg <= ST_IDLE;
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // storage access: address after pre-decrement for writes
    always_comb begin
        stkReq   = (state_reg == ST_WRITE) || (state_reg == ST_READ);
        stkWrite = (state_reg == ST_WRITE); // reads never write
        stkAddr  = (state_reg == ST_WRITE) ? curPtr - 16'h0001 : curPtr;
        if (curInt) stkAddr = {8'h00, stkAddr[7:0]};
        stkInRegFile = curInt;
        stkWdata     = item_reg[idx_reg];
    end

    // popped results presented from the item store
    always_comb begin
        // a finished byte pop leaves the index at one
        popData    = (op_reg == OP_POP && idx_reg == 3'h1)
                   ? {8'h00, item_reg[0]} : {item_reg[0], item_reg[1]};
        popFlags   = item_reg[0];
        popPc      = (op_reg == OP_IRET) ? {item_reg[1], item_reg[2]}
                                         : {item_reg[0], item_reg[1]};
        popCodeSeg = (op_reg == OP_IRET) ? item_reg[3] : item_reg[2];
    end

    assign opBusy = (state_reg != ST_IDLE);

    // clock divider settings from the mode register
    clock_prescaler u_prescaler (
        .clock             (clock),
        .resetn            (resetn),
        .oscHalving        (mode_reg[`MODE_HALF_BIT]),
        .coreClockPrescale (mode_reg[`MODE_SCALE_HI:`MODE_SCALE_LO]),
        .coreTick          (coreTick)
    );

    // external bus request gating and float control
    ext_bus_gate #(.PORT_W(PORT_W)) u_bus_gate (
        .clock           (clock),
        .resetn          (resetn),
        .busRequestAllow (mode_reg[`MODE_BRQ_BIT]),
        .extBusFloat     (mode_reg[`MODE_FLOAT_BIT]),
        .busRequestPin   (busRequestPin),
        .portIsAddress   (portIsAddress),
        .busRequest      (busRequest),
        .portFloat       (portFloat),
        .ctrlFloat       (ctrlFloat)
    );
endmodule : core_mode_stack

/* File: src/ext_bus_gate.sv */
// bus request gate and external interface float control
`timescale 1ns/1ns
module ext_bus_gate
    import core_mode_pkg::*;
#(
    parameter int PORT_W = 8
) (
    // clock and reset
    input  wire logic              clock,
    input  wire logic              resetn,
    // controls
    input  wire logic              busRequestAllow,
    input  wire logic              extBusFloat,
    input  wire logic              busRequestPin,
    input  wire logic [PORT_W-1:0] portIsAddress,
    // results
    output logic                   busRequest,
    output logic [PORT_W-1:0]      portFloat,
    output logic                   ctrlFloat
);
    logic reqMeta_reg;
    logic reqSync_reg;

    // two-stage synchroniser for the request pin
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            reqMeta_reg <= 1'b0;
            reqSync_reg <= 1'b0;
        end else begin
            reqMeta_reg <= busRequestPin;
            reqSync_reg <= reqMeta_reg;
        end
    end

    // registered gated outputs
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            busRequest <= 1'b0;
            portFloat  <= '0;
            ctrlFloat  <= 1'b0;
        end else begin
            busRequest <= busRequestAllow & reqSync_reg;
            portFloat  <= {PORT_W{extBusFloat}} & portIsAddress;
            ctrlFloat  <= extBusFloat;
        end
    end
endmodule : ext_bus_gate

/* File: tb/core_mode_stack_assertions.sv */
// concurrent checks on the core mode and stack pointer block ports
`timescale 1ns/1ns
module core_mode_stack_checker
    import core_mode_pkg::*;
#(
    parameter int PORT_W = 8
) (
    // clock and reset
    input wire logic              clock,
    input wire logic              resetn,
    // register and operation ports
    input wire logic [7:0]        regAddr,
    input wire logic [7:0]        regRdata,
    input wire logic              opStart,
    input wire logic [3:0]        opCode,
    input wire logic              opWord,
    input wire logic              opBusy,
    input wire logic              opDone,
    // storage and bus ports
    input wire logic              stkReq,
    input wire logic              stkWrite,
    input wire logic              stkInRegFile,
    input wire logic [15:0]       stkAddr,
    input wire logic              busRequestPin,
    input wire logic              busRequest,
    input wire logic [PORT_W-1:0] portIsAddress,
    input wire logic [PORT_W-1:0] portFloat
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    // accepted byte push, word push and pop requests
    logic pushByte;
    logic pushWord;
    logic popAny;
    assign pushByte = opStart && !opBusy && opCode == OP_PUSH && !opWord;
    assign pushWord = opStart && !opBusy && opCode == OP_PUSH && opWord;
    assign popAny   = opStart && !opBusy && opCode == OP_POP;

    reg_map_a: assert property (
        (regAddr < 8'heb || regAddr > 8'hef) |-> regRdata == 8'h00)
        else $error("unmapped register read not zero");
    push_first_a: assert property (
        pushByte |=> stkReq && stkWrite ##1 !stkReq)
        else $error("byte push did not write one byte");
    push_done_a: assert property (
        pushByte |-> !opDone [*3] ##1 opDone)
        else $error("byte push done at wrong cycle");
    pop_read_a: assert property (
        popAny |=> !stkWrite [*3])
        else $error("pop wrote to stack storage");
    word_order_a: assert property (
        pushWord |=> stkWrite ##1 (stkWrite && stkAddr == $past(stkAddr) - 16'h1))
        else $error("word push byte order wrong");
    regfile_high_a: assert property (
        stkReq && stkInRegFile |-> stkAddr[15:8] == 8'h00)
        else $error("register file stack address high byte set");
    busreq_idle_a: assert property (
        (!busRequestPin) [*3] |=> !busRequest)
        else $error("bus request without pin");
    float_io_a: assert property (
        $stable(portIsAddress) |-> (portFloat & ~portIsAddress) == '0)
        else $error("general purpose pin floated");
    done_idle_a: assert property (
        opDone |-> !opBusy && !stkReq)
        else $error("busy or storage access at done");
endmodule : core_mode_stack_checker

bind core_mode_stack core_mode_stack_checker #(.PORT_W(PORT_W)) checker_i (
    .clock(clock), .resetn(resetn), .regAddr(regAddr), .regRdata(regRdata),
    .opStart(opStart), .opCode(opCode), .opWord(opWord), .opBusy(opBusy),
    .opDone(opDone), .stkReq(stkReq), .stkWrite(stkWrite),
    .stkInRegFile(stkInRegFile), .stkAddr(stkAddr),
    .busRequestPin(busRequestPin), .busRequest(busRequest),
    .portIsAddress(portIsAddress), .portFloat(portFloat));

/* File: tb/tb.sv */
// self-checking bench for the core mode and stack pointer block
`timescale 1ns/1ns
module tb
    import core_mode_pkg::*;
;
    logic clock, resetn, regWrite, opStart, opUser, opWord, sse, busPin;
    logic [7:0]  regAddr, regWdata, regRdata, opFlags, opCodeSeg, stkWdata;
    logic [7:0]  stkRdata, portIsAddress, portFloat;
    logic [3:0]  opCode;
    logic [15:0] opData, opPc, opFrameLen, popData, popPc, stkAddr, v;
    logic [7:0]  popFlags, popCodeSeg;
    logic        opBusy, opDone, stkReq, stkWrite, stkInRegFile, lastInReg;
    logic        coreTick, busRequest, ctrlFloat;
    logic [7:0]  mem [0:65535];
    int          fails, cmpCount, nTick;

    core_mode_stack core_mode_stack_i (
        .clock(clock), .resetn(resetn), .regAddr(regAddr),
        .regWrite(regWrite), .regWdata(regWdata), .regRdata(regRdata),
        .opStart(opStart), .opCode(opCode), .opUser(opUser), .opWord(opWord),
        .opData(opData), .opPc(opPc), .opFlags(opFlags),
        .opCodeSeg(opCodeSeg), .opFrameLen(opFrameLen),
        .segmentSaveEnable(sse), .opBusy(opBusy), .opDone(opDone),
        .popData(popData), .popPc(popPc), .popFlags(popFlags),
        .popCodeSeg(popCodeSeg), .stkReq(stkReq), .stkWrite(stkWrite),
        .stkInRegFile(stkInRegFile), .stkAddr(stkAddr),
        .stkWdata(stkWdata), .stkRdata(stkRdata), .busRequestPin(busPin),
        .portIsAddress(portIsAddress), .coreTick(coreTick),
        .busRequest(busRequest), .portFloat(portFloat),
        .ctrlFloat(ctrlFloat));

    // stack storage behind the block
    assign stkRdata = mem[stkAddr];
    always @(posedge clock) begin
        if (stkReq && stkWrite) begin
            mem[stkAddr] <= stkWdata;
            lastInReg    <= stkInRegFile;
        end
    end

    // free running clock
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", cmpCount, fails);
        if (fails == 0 && cmpCount > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : summarize

    task automatic chk(input string name, input logic [15:0] exp,
                       input logic [15:0] got);
        cmpCount++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        regAddr  <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clock);
        regWrite <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        regAddr <= a;
        #1;
        d = regRdata;
    endtask : rd

    task automatic setPtr(input logic [7:0] hi, input logic [15:0] p);
        wr(hi, p[15:8]);
        wr(hi + 8'h1, p[7:0]);
    endtask : setPtr

    task automatic getPtr(input logic [7:0] hi, output logic [15:0] p);
        rd(hi, p[15:8]);
        rd(hi + 8'h1, p[7:0]);
    endtask : getPtr

    // one stack operation, waits a bounded time for its done pulse
    task automatic doOp(input logic [3:0] c, input logic u, input logic w,
                        input logic [15:0] d);
        bit seen;
        seen = 0;
        @(posedge clock);
        opCode  <= c;
        opUser  <= u;
        opWord  <= w;
        opData  <= d;
        opStart <= 1'b1;
        @(posedge clock);
        opStart <= 1'b0;
        for (int i = 0; i < 20 && !seen; i++) begin
            @(posedge clock);
            #1;
            seen = (opDone === 1'b1);
        end
        chk("opDone", 16'h1, {15'h0, seen});
    endtask : doOp

    // ordinary register rows: address, written value, read back value
    logic [7:0] rowA [6] = '{8'hec, 8'hed, 8'hee, 8'hef, 8'hf0, 8'heb};
    logic [7:0] rowD [6] = '{8'h12, 8'h34, 8'h56, 8'h78, 8'haa, 8'h5c};
    logic [7:0] rowE [6] = '{8'h12, 8'h34, 8'h56, 8'h78, 8'h00, 8'h5c};
    // entry operations, their returns and the bytes they stack
    logic [3:0] entOp [4] = '{OP_INT, OP_INT, OP_CALL, OP_CALLS};
    logic [3:0] retOp [4] = '{OP_IRET, OP_IRET, OP_RET, OP_RETS};
    logic [15:0] nByte [4] = '{16'h4, 16'h3, 16'h2, 16'h3};
    logic       segOn [4] = '{1'b1, 1'b0, 1'b0, 1'b1};

    // watchdog far beyond the expected run length
    initial begin
        repeat (20000) @(posedge clock);
        fails++;
        summarize();
    end

    initial begin
        resetn = 1'b0; regWrite = 1'b0; opStart = 1'b0; opUser = 1'b0;
        opWord = 1'b0; sse = 1'b0; busPin = 1'b0; regAddr = 8'h00;
        regWdata = 8'h00; opFlags = 8'h5a; opCodeSeg = 8'h07;
        opCode = 4'h0; opData = 16'h0; opPc = 16'h1234;
        opFrameLen = 16'h0010; portIsAddress = 8'h0f;
        fails = 0; cmpCount = 0;
        repeat (10) @(posedge clock);
        resetn <= 1'b1;
        rd(8'heb, v[7:0]);
        chk("mode reset", 16'h00e0, {8'h0, v[7:0]});
        for (int i = 0; i < 6; i++) begin
            wr(rowA[i], rowD[i]);
            rd(rowA[i], v[7:0]);
            chk("register", {8'h0, rowE[i]}, {8'h0, v[7:0]});
        end
        // byte push and pop on a register file system stack
        wr(8'heb, 8'he0);
        setPtr(8'hee, 16'h1280);
        doOp(OP_PUSH, 1'b0, 1'b0, 16'h00a5);
        chk("regfile byte", 16'h00a5, {8'h0, mem[16'h007f]});
        chk("in regfile", 16'h1, {15'h0, lastInReg});
        getPtr(8'hee, v);
        chk("sys ptr after push", 16'h127f, v);
        doOp(OP_POP, 1'b0, 1'b0, 16'h0);
        chk("pop byte", 16'h00a5, popData);
        chk("kept byte", 16'h00a5, {8'h0, mem[16'h007f]});
        getPtr(8'hee, v);
        chk("sys ptr after pop", 16'h1280, v);
        // word push and pop on a memory user stack
        wr(8'heb, 8'ha0);
        setPtr(8'hec, 16'h2000);
        doOp(OP_PUSH, 1'b1, 1'b1, 16'hbeef);
        chk("word high", 16'h00be, {8'h0, mem[16'h1ffe]});
        chk("word low", 16'h00ef, {8'h0, mem[16'h1fff]});
        chk("in memory", 16'h0, {15'h0, lastInReg});
        getPtr(8'hec, v);
        chk("user ptr after push", 16'h1ffe, v);
        doOp(OP_POP, 1'b1, 1'b1, 16'h0);
        chk("pop word", 16'hbeef, popData);
        getPtr(8'hec, v);
        chk("user ptr after pop", 16'h2000, v);
        // automatic pushes and their returns on a memory system stack
        wr(8'heb, 8'h20);
        for (int i = 0; i < 4; i++) begin
            sse <= segOn[i];
            setPtr(8'hee, 16'h3000);
            doOp(entOp[i], 1'b0, 1'b0, 16'h0);
            getPtr(8'hee, v);
            chk("entry ptr", 16'h3000 - nByte[i], v);
            if (i == 0) begin
                chk("int flags", 16'h005a, {8'h0, mem[16'h2ffc]});
                chk("int segment", 16'h0007, {8'h0, mem[16'h2fff]});
            end
            doOp(retOp[i], 1'b0, 1'b0, 16'h0);
            chk("return pc", 16'h1234, popPc);
            if (segOn[i]) begin
                chk("return seg", 16'h0007, {8'h0, popCodeSeg});
            end
            getPtr(8'hee, v);
            chk("return ptr", 16'h3000, v);
        end
        // user frame link reserves pointer plus frame length
        setPtr(8'hec, 16'h2000);
        doOp(OP_LINK, 1'b1, 1'b0, 16'hc0de);
        getPtr(8'hec, v);
        chk("link ptr", 16'h1fee, v);
        // core restores the frame pointer, then unlink pops it back
        setPtr(8'hec, 16'h1ffe);
        doOp(OP_UNLINK, 1'b1, 1'b0, 16'h0);
        chk("unlink data", 16'hc0de, popData);
        getPtr(8'hec, v);
        chk("unlink ptr", 16'h2000, v);
        // bus request gate and interface float
        wr(8'heb, 8'h22);
        busPin <= 1'b1;
        repeat (5) @(posedge clock);
        chk("bus request on", 16'h1, {15'h0, busRequest});
        wr(8'heb, 8'h21);
        repeat (5) @(posedge clock);
        chk("bus request off", 16'h0, {15'h0, busRequest});
        chk("port float", 16'h000f, {8'h0, portFloat});
        chk("ctrl float", 16'h1, {15'h0, ctrlFloat});
        wr(8'heb, 8'h20);
        repeat (2) @(posedge clock);
        chk("float cleared", 16'h0, {7'h0, ctrlFloat, portFloat});
        // halving on and prescale field 1: one tick every four clocks
        wr(8'heb, 8'h24);
        nTick = 0;
        repeat (16) begin
            @(posedge clock);
            #1;
            nTick += coreTick;
        end
        chk("core ticks", 16'h4, nTick[15:0]);
        summarize();
    end
endmodule : tb
